// *** otc_top.sv ***
// Holds the register file, motion accumulation, power-down, software reset
// and emitter pulse drive of the optical tracker control block.
// Assumes serial pins and sensing-core strobes are synchronous to core_clk.
`timescale 1ns/1ps
module otc_top
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Three-wire serial pins
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  // Sensing core
  input wire logic motion_stb,
  input wire logic [7:0] motion_dx,
  input wire logic [7:0] motion_dy,
  input wire logic [7:0] surface_quality_value,
  // Control outputs
  output logic sleep_mode,
  output logic [4:0] emitter_current_setting,
  output logic laser_pulse
);

  // ----------------------------------------------------------------
  // Serial link
  // ----------------------------------------------------------------
  otc_pkg::otc_req_s req; // Decoded request pulses
  logic [7:0] rd_q, rd_d; // Read data held for the link

  otc_spi_link i_otc_spi_link
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .ncs_n(ncs_n),
    .sclk(sclk),
    .sdio_i(sdio_i),
    .sdio_o(sdio_o),
    .sdio_oe(sdio_oe),
    .rd_data(rd_q),
    .req(req)
  );

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [7:0] cfg_q, cfg_d; // Configuration, reset bit never stored
  logic [4:0] emit_q, emit_d; // Emitter current code
  logic srst_q, srst_d; // Software reset pending, one cycle
  logic flag_q, flag_d; // Movement pending
  logic [15:0] acc_x_q, acc_x_d; // Running horizontal sum
  logic [15:0] acc_y_q, acc_y_d; // Running vertical sum
  logic [15:0] dx_q, dx_d; // Snapshot shown to the host
  logic [15:0] dy_q, dy_d;
  logic [11:0] lcnt_q, lcnt_d; // Pulse period counter
  logic laser_q, laser_d;
  logic regs_rst; // Internal register reset
  logic asleep;
  logic wr_cfg;
  logic wr_emit;
  logic snap;
  logic moved;

  // Internal reset from the system reset or a software reset
  // A frozen clock enable also holds off a pending software reset
  assign regs_rst = ~nrst | (srst_q & clk_en);
  assign asleep = cfg_q[otc_pkg::OTC_CFG_SLEEP_BIT];
  assign wr_cfg = req.wr && req.addr == otc_pkg::OTC_ADDR_CFG;
  assign wr_emit = req.wr && req.addr == otc_pkg::OTC_ADDR_EMIT;
  // Reading the flag register freezes the sums for the host
  assign snap = req.rd && req.addr == otc_pkg::OTC_ADDR_FLAG;
  // Motion is ignored while asleep; the sensing path is stopped
  assign moved = motion_stb && !asleep && (motion_dx != otc_pkg::OTC_BYTE_ZERO
    || motion_dy != otc_pkg::OTC_BYTE_ZERO);

  // ----------------------------------------------------------------
  // Configuration and emitter registers
  // ----------------------------------------------------------------
  // Register writes stay open in power-down
  always_comb
  begin
    cfg_d = cfg_q;
    emit_d = emit_q;
    srst_d = 1'b0;
    if (wr_cfg)
    begin
      // Sleep bit set enters, cleared leaves power-down
      cfg_d = req.data;
      // Reset bit is a trigger, so it reads back as zero
      cfg_d[otc_pkg::OTC_CFG_SRST_BIT] = 1'b0;
      srst_d = req.data[otc_pkg::OTC_CFG_SRST_BIT];
    end
    if (wr_emit)
    begin
      // Full five-bit range taken; limiting is software's job
      emit_d = req.data[otc_pkg::OTC_EMIT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Motion accumulation and snapshot
  // ----------------------------------------------------------------
  // A new event in the snapshot cycle starts the next sum; set wins
  always_comb
  begin
    acc_x_d = snap ? otc_pkg::OTC_ACC_ZERO : acc_x_q;
    acc_y_d = snap ? otc_pkg::OTC_ACC_ZERO : acc_y_q;
    flag_d = snap ? 1'b0 : flag_q;
    dx_d = dx_q;
    dy_d = dy_q;
    if (snap)
    begin
      // Without pending motion the host sees zero, never stale data
      dx_d = flag_q ? acc_x_q : otc_pkg::OTC_ACC_ZERO;
      dy_d = flag_q ? acc_y_q : otc_pkg::OTC_ACC_ZERO;
    end
    if (moved)
    begin
      // Sign-extended sum; wraps if the host polls far too slowly
      acc_x_d = acc_x_d + {{8{motion_dx[7]}}, motion_dx};
      acc_y_d = acc_y_d + {{8{motion_dy[7]}}, motion_dy};
      flag_d = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Latched one cycle after the address byte, long before it is shifted
  always_comb
  begin
    rd_d = rd_q;
    if (req.rd)
    begin
      case (req.addr)
        otc_pkg::OTC_ADDR_FLAG:
        begin
          rd_d = otc_pkg::OTC_BYTE_ZERO;
          rd_d[otc_pkg::OTC_FLAG_MOTION_BIT] = flag_q;
        end
        otc_pkg::OTC_ADDR_DX_LO: rd_d = dx_q[7:0];
        otc_pkg::OTC_ADDR_DX_HI: rd_d = dx_q[15:8];
        otc_pkg::OTC_ADDR_DY_LO: rd_d = dy_q[7:0];
        otc_pkg::OTC_ADDR_DY_HI: rd_d = dy_q[15:8];
        otc_pkg::OTC_ADDR_CFG: rd_d = cfg_q;
        otc_pkg::OTC_ADDR_QUAL: rd_d = surface_quality_value;
        otc_pkg::OTC_ADDR_EMIT: rd_d = {3'h0, emit_q};
        // Unmapped addresses read as zero
        default: rd_d = otc_pkg::OTC_BYTE_ZERO;
      endcase
    end
  end

  // Read latch keeps its byte until the next read request

  // ----------------------------------------------------------------
  // Emitter pulse train
  // ----------------------------------------------------------------
  // Duty well under one; the emitter is never held on
  always_comb
  begin
    lcnt_d = lcnt_q + otc_pkg::OTC_CNT_ONE;
    if (lcnt_q == otc_pkg::OTC_LASER_PERIOD_CYC - otc_pkg::OTC_CNT_ONE)
    begin
      lcnt_d = otc_pkg::OTC_CNT_ZERO;
    end
    laser_d = lcnt_q < otc_pkg::OTC_LASER_ON_CYC;
    if (asleep)
    begin
      // Lowest power: counter parked, emitter dark
      lcnt_d = otc_pkg::OTC_CNT_ZERO;
      laser_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Register file and engine go to defaults on either reset
  always_ff @(posedge core_clk)
  begin
    if (regs_rst)
    begin
      cfg_q <= otc_pkg::OTC_CFG_RST;
      emit_q <= otc_pkg::OTC_EMIT_RST;
      flag_q <= 1'b0;
      acc_x_q <= otc_pkg::OTC_ACC_ZERO;
      acc_y_q <= otc_pkg::OTC_ACC_ZERO;
      dx_q <= otc_pkg::OTC_ACC_ZERO;
      dy_q <= otc_pkg::OTC_ACC_ZERO;
      lcnt_q <= otc_pkg::OTC_CNT_ZERO;
      laser_q <= 1'b0;
      rd_q <= otc_pkg::OTC_BYTE_ZERO;
    end
    else if (clk_en)
    begin
      cfg_q <= cfg_d;
      emit_q <= emit_d;
      flag_q <= flag_d;
      acc_x_q <= acc_x_d;
      acc_y_q <= acc_y_d;
      dx_q <= dx_d;
      dy_q <= dy_d;
      lcnt_q <= lcnt_d;
      laser_q <= laser_d;
      rd_q <= rd_d;
    end
  end

  // Reset trigger lives outside the register reset so it ends itself
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      srst_q <= 1'b0;
    end
    else if (clk_en)
    begin
      srst_q <= srst_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------------------------------
  assign sleep_mode = cfg_q[otc_pkg::OTC_CFG_SLEEP_BIT];
  assign emitter_current_setting = emit_q;
  assign laser_pulse = laser_q;

endmodule // otc_top

// *** otc_pkg.sv ***
// Package: shared constants and carrier types for the tracker control block.
// Assumes a single 200 MHz core clock; all users refer to otc_pkg::name.
package otc_pkg;

  // ----------------------------------------------------------------
  // Register addresses (7-bit serial address space)
  // ----------------------------------------------------------------
  localparam logic [6:0] OTC_ADDR_FLAG = 7'h02; // Movement flag, RO
  localparam logic [6:0] OTC_ADDR_DX_LO = 7'h03; // Horizontal, low byte
  localparam logic [6:0] OTC_ADDR_DY_LO = 7'h04; // Vertical, low byte
  localparam logic [6:0] OTC_ADDR_CFG = 7'h06; // Configuration, RW
  localparam logic [6:0] OTC_ADDR_QUAL = 7'h07; // Surface quality, RO
  localparam logic [6:0] OTC_ADDR_DX_HI = 7'h11; // Horizontal, high byte
  localparam logic [6:0] OTC_ADDR_DY_HI = 7'h12; // Vertical, high byte
  localparam logic [6:0] OTC_ADDR_EMIT = 7'h51; // Emitter current, RW

  // ----------------------------------------------------------------
  // Field positions, widths and reset values
  // ----------------------------------------------------------------
  localparam int OTC_FLAG_MOTION_BIT = 7; // Movement pending flag
  localparam int OTC_CFG_SLEEP_BIT = 3; // Sleep request bit
  localparam int OTC_CFG_SRST_BIT = 7; // Software reset bit
  localparam int OTC_EMIT_W = 5; // Emitter current field width
  localparam logic [7:0] OTC_CFG_RST = 8'h00;
  localparam logic [4:0] OTC_EMIT_RST = 5'h0e;
  localparam logic [7:0] OTC_BYTE_ZERO = 8'h00;
  localparam logic [15:0] OTC_ACC_ZERO = 16'h0000;

  // ----------------------------------------------------------------
  // Serial frame layout
  // ----------------------------------------------------------------
  localparam int OTC_DIR_BIT = 7; // 1 = write, 0 = read
  localparam logic [4:0] OTC_BITS_ADDR = 5'h08; // Bits in address byte
  localparam logic [4:0] OTC_BITS_FRAME = 5'h10; // Bits in whole frame

  // ----------------------------------------------------------------
  // Timing: emitter pulse train
  // ----------------------------------------------------------------
  localparam int OTC_CLK_MHZ = 200;
  localparam int OTC_LASER_PERIOD_NS = 10000; // Least pulse period
  localparam int OTC_LASER_ON_NS = 1000; // Longest pulse width
  // Least time rounds up, longest time rounds down
  localparam logic [11:0] OTC_LASER_PERIOD_CYC =
    12'((OTC_LASER_PERIOD_NS * OTC_CLK_MHZ + 999) / 1000);
  localparam logic [11:0] OTC_LASER_ON_CYC =
    12'((OTC_LASER_ON_NS * OTC_CLK_MHZ) / 1000);
  localparam logic [11:0] OTC_CNT_ONE = 12'h001;
  localparam logic [11:0] OTC_CNT_ZERO = 12'h000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  // Serial link states, Gray coded along idle-addr-wdata; addr to rdata changes two bits
  typedef enum logic [1:0] {
    OTC_IDLE = 2'b00,
    OTC_ADDR = 2'b01,
    OTC_WDATA = 2'b11,
    OTC_RDATA = 2'b10
  } otc_link_e;

  // One decoded register request from the serial link
  typedef struct packed {
    logic wr; // One-cycle write strobe
    logic rd; // One-cycle read request
    logic [6:0] addr; // Register address
    logic [7:0] data; // Write data
  } otc_req_s;

endpackage

// *** otc_spi_link.sv ***
// Holds the three-wire half-duplex serial slave of the tracker control block.
// Assumes the pins are synchronous to core_clk and sclk is much slower.
`timescale 1ns/1ps
module otc_spi_link
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Serial pins
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  // Register side
  input wire logic [7:0] rd_data,
  output otc_pkg::otc_req_s req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  otc_pkg::otc_link_e st_q, st_d; // Frame phase
  logic sclk_q, sclk_d; // Previous clock level for edge detect
  logic [4:0] cnt_q, cnt_d; // Bits taken in this frame
  logic [7:0] sh_q, sh_d; // Input shift register
  logic [6:0] addr_q, addr_d; // Captured address
  logic [7:0] out_q, out_d; // Output shift register
  logic sdo_q, sdo_d;
  logic oe_q, oe_d;
  otc_pkg::otc_req_s req_q, req_d;
  logic rise;
  logic fall;

  // Edges of the host clock as seen on core_clk
  assign rise = sclk & ~sclk_q;
  assign fall = ~sclk & sclk_q;

  // Next-state logic: bits in on rise, read data out on fall
  always_comb
  begin
    st_d = st_q;
    sclk_d = sclk;
    cnt_d = cnt_q;
    sh_d = sh_q;
    addr_d = addr_q;
    out_d = out_q;
    sdo_d = sdo_q;
    oe_d = oe_q;
    req_d = '0;
    req_d.addr = addr_q;
    req_d.data = sh_q;
    if (ncs_n)
    begin
      // Deselect also recovers from a broken frame
      st_d = otc_pkg::OTC_IDLE;
      cnt_d = '0;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        otc_pkg::OTC_IDLE:
        begin
          st_d = otc_pkg::OTC_ADDR;
        end
        otc_pkg::OTC_ADDR:
        begin
          if (rise)
          begin
            sh_d = {sh_q[6:0], sdio_i};
            cnt_d = cnt_q + 5'h01;
            if (cnt_d == otc_pkg::OTC_BITS_ADDR)
            begin
              addr_d = sh_d[6:0];
              req_d.addr = sh_d[6:0];
              // Direction flag in the first bit of the frame
              if (sh_d[otc_pkg::OTC_DIR_BIT])
              begin
                st_d = otc_pkg::OTC_WDATA;
              end
              else
              begin
                st_d = otc_pkg::OTC_RDATA;
                req_d.rd = 1'b1;
              end
            end
          end
        end
        otc_pkg::OTC_WDATA:
        begin
          if (rise && cnt_q != otc_pkg::OTC_BITS_FRAME)
          begin
            sh_d = {sh_q[6:0], sdio_i};
            cnt_d = cnt_q + 5'h01;
            if (cnt_d == otc_pkg::OTC_BITS_FRAME)
            begin
              req_d.wr = 1'b1;
              req_d.data = sh_d;
            end
          end
        end
        otc_pkg::OTC_RDATA:
        begin
          // Read data was latched well before the first falling edge
          if (fall && cnt_q != otc_pkg::OTC_BITS_FRAME)
          begin
            if (cnt_q == otc_pkg::OTC_BITS_ADDR)
            begin
              sdo_d = rd_data[7];
              out_d = {rd_data[6:0], 1'b0};
            end
            else
            begin
              sdo_d = out_q[7];
              out_d = {out_q[6:0], 1'b0};
            end
            oe_d = 1'b1;
          end
          if (rise && cnt_q != otc_pkg::OTC_BITS_FRAME)
          begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        default:
        begin
          st_d = otc_pkg::OTC_IDLE;
        end
      endcase
    end
  end

  // Registers only; clock enable freezes everything
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      st_q <= otc_pkg::OTC_IDLE;
      sclk_q <= 1'b0;
      cnt_q <= '0;
      sh_q <= '0;
      addr_q <= '0;
      out_q <= '0;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      req_q <= '0;
    end
    else if (clk_en)
    begin
      st_q <= st_d;
      sclk_q <= sclk_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      addr_q <= addr_d;
      out_q <= out_d;
      sdo_q <= sdo_d;
      oe_q <= oe_d;
      req_q <= req_d;
    end
  end

  assign sdio_o = sdo_q;
  assign sdio_oe = oe_q;
  assign req = req_q;

endmodule // otc_spi_link

// *** otc_host_model.sv ***
// Host model driving the three-wire serial pins of the tracker.
// Assumes the bench resolves the shared data line and feeds it back.
`timescale 1ns/1ps
module otc_host_model
(
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic ncs_n,
  output logic sclk,
  output logic h_o,
  output logic h_oe,
  input wire logic sdio_line
);
  // Four cycles a phase, above the two the slave needs
  localparam int PH = 4;
  // Idle: deselected, clock high, line released
  initial
  begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    h_o = 1'b0;
    h_oe = 1'b0;
  end
  // Let n edges pass, then act just after the last
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One frame: address byte with direction flag, then data byte
  task automatic xfer(input logic wr, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {wr, a, d};
    q = 8'h00;
    tick(1);
    ncs_n = 1'b0;
    tick(PH);
    for (int i = 15; i >= 0; i--)
    begin
      // Data changes on the fall, MSB first
      sclk = 1'b0;
      h_oe = wr || (i > 7);
      h_o = f[i];
      tick(PH);
      // Sample just before the rise, when the slave has settled
      if (!wr && i < 8)
        q = {q[6:0], sdio_line};
      sclk = 1'b1;
      tick(PH);
    end
    // Long lag so a software reset lands inside the frame
    tick(PH);
    ncs_n = 1'b1;
    h_oe = 1'b0;
    tick(PH);
  endtask
endmodule // otc_host_model

// *** otc_top_properties.sv ***
// Concurrent checks on the ports of the tracker control top module.
// Assumes one core_clk domain with synchronous active-low nrst.
`timescale 1ns/1ps
module otc_top_properties
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Serial pins
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  // Control outputs
  input wire logic sleep_mode,
  input wire logic [4:0] emitter_current_setting,
  input wire logic laser_pulse
);
  // Length of the current laser high run; saturates, never wraps
  logic [11:0] hi_q;
  logic [11:0] hi_d;
  // Next run length
  always_comb
  begin
    hi_d = 12'h000;
    if (nrst && laser_pulse)
      hi_d = (hi_q == 12'hfff) ? hi_q : hi_q + 12'h001;
  end
  // Register the run length
  always_ff @(posedge core_clk)
  begin
    hi_q <= hi_d;
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  pulse_width_a: assert property (
    hi_q <= otc_pkg::OTC_LASER_ON_CYC) else $error("laser pulse too long");
  sleep_dark_a: assert property (
    sleep_mode && $past(sleep_mode) |-> !laser_pulse)
    else $error("laser pulsing while asleep");
  reset_vals_a: assert property (
    $rose(nrst) |-> emitter_current_setting == otc_pkg::OTC_EMIT_RST
    && !sleep_mode && !sdio_oe) else $error("bad values after reset");
  oe_select_a: assert property (
    $rose(sdio_oe) |-> !ncs_n) else $error("data driven while deselected");
  oe_release_a: assert property (
    ncs_n && $past(ncs_n) |-> !sdio_oe) else $error("data line not released");
  sdio_hold_a: assert property (
    sdio_oe && $past(sdio_oe) && sclk && $past(sclk) && $past(sclk, 2)
    |-> $stable(sdio_o)) else $error("data changed while clock high");
  emit_frame_a: assert property (
    $changed(emitter_current_setting) |-> !ncs_n)
    else $error("emitter code changed outside a frame");
  sleep_frame_a: assert property (
    $changed(sleep_mode) |-> !ncs_n) else $error("sleep changed outside frame");
  pulse_seen_c: cover property ($rose(laser_pulse));
  read_seen_c: cover property ($rose(sdio_oe));
  sleep_seen_c: cover property ($rose(sleep_mode));
  emit_seen_c: cover property ($changed(emitter_current_setting));
endmodule // otc_top_properties

bind otc_top otc_top_properties i_otc_top_properties (
  .core_clk(core_clk), .nrst(nrst), .ncs_n(ncs_n), .sclk(sclk),
  .sdio_o(sdio_o), .sdio_oe(sdio_oe), .sleep_mode(sleep_mode),
  .emitter_current_setting(emitter_current_setting),
  .laser_pulse(laser_pulse));

// *** otc_top_bench.sv ***
// Self-checking bench for the tracker control block and its host model.
// Assumes one 200 MHz clock; the host model owns the serial pins.
`timescale 1ns/1ps
module otc_top_bench;
  // Wake guard shortened from 3 ms to keep the run short
  localparam int WAKE = 32'h0000_00c8;
  logic core_clk, nrst, clk_en, ncs_n, sclk, sdio_i, sdio_o, sdio_oe;
  logic h_o, h_oe, last_q, motion_stb, sleep_mode, laser_pulse;
  logic [7:0] motion_dx, motion_dy, surface_quality_value, rd;
  logic [4:0] emit;
  int failures = 0;
  int compares = 0;
  // Released line shows the inverse of its last level
  assign sdio_i = sdio_oe ? sdio_o : h_oe ? h_o : ~last_q;
  always @(posedge core_clk) last_q <= sdio_i;
  // Clock: invert every half period
  always #2.5 core_clk = ~core_clk;
  otc_top i_otc_top (.core_clk(core_clk), .nrst(nrst), .clk_en(clk_en),
    .ncs_n(ncs_n), .sclk(sclk), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .motion_stb(motion_stb), .motion_dx(motion_dx),
    .motion_dy(motion_dy), .surface_quality_value(surface_quality_value),
    .sleep_mode(sleep_mode), .emitter_current_setting(emit),
    .laser_pulse(laser_pulse));
  otc_host_model i_otc_host_model (.core_clk(core_clk), .ncs_n(ncs_n),
    .sclk(sclk), .h_o(h_o), .h_oe(h_oe), .sdio_line(sdio_i));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_otc_host_model.xfer(1'b1, a, d, rd);
  endtask
  task automatic rchk(input string nm, input logic [6:0] a,
    input logic [7:0] e);
    i_otc_host_model.xfer(1'b0, a, 8'h00, rd);
    chk(nm, {8'h00, e}, {8'h00, rd});
  endtask
  // One-cycle motion event
  task automatic mot(input logic [7:0] x, input logic [7:0] y);
    motion_dx = x;
    motion_dy = y;
    motion_stb = 1'b1;
    @(posedge core_clk);
    #1;
    motion_stb = 1'b0;
  endtask
  // Cycles the laser output stays at v, capped so a hang cannot occur
  task automatic run(input logic v, output int n);
    n = 0;
    while (laser_pulse === v && n < 4000)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("emit_pin", 16'h000e, {11'h0, emit});
    chk("sleep_pin", 16'h0000, {15'h0, sleep_mode});
    rchk("cfg", 7'h06, 8'h00);
    rchk("emit", 7'h51, 8'h0e);
    rchk("unmapped", 7'h7f, 8'h00);
    wr(7'h02, 8'hff);
    rchk("flag_ro", 7'h02, 8'h00);
    rchk("quality", 7'h07, 8'h5a);
  endtask
  task automatic t_motion();
    mot(8'h00, 8'h00);
    rchk("flag_idle", 7'h02, 8'h00);
    mot(8'h03, 8'hfe);
    mot(8'h05, 8'h01);
    rchk("flag_set", 7'h02, 8'h80);
    rchk("dx_lo", 7'h03, 8'h08);
    rchk("dx_hi", 7'h11, 8'h00);
    rchk("dy_lo", 7'h04, 8'hff);
    rchk("dy_hi", 7'h12, 8'hff);
    rchk("flag_clr", 7'h02, 8'h00);
  endtask
  task automatic t_emit();
    logic [7:0] c [4] = '{8'h06, 8'h1f, 8'h00, 8'hff};
    foreach (c[i])
    begin
      wr(7'h51, c[i]);
      chk("emit_pin", {8'h00, c[i] & 8'h1f}, {11'h0, emit});
      rchk("emit", 7'h51, c[i] & 8'h1f);
    end
    wr(7'h51, 8'h06);
  endtask
  task automatic t_pulse();
    int n;
    run(1'b0, n);
    run(1'b1, n);
    run(1'b0, n);
    chk("low_run", 16'(otc_pkg::OTC_LASER_PERIOD_CYC
      - otc_pkg::OTC_LASER_ON_CYC), 16'(n));
    run(1'b1, n);
    chk("high_run", 16'(otc_pkg::OTC_LASER_ON_CYC), 16'(n));
    // Low clock enable must park the pulse counter where it stands
    clk_en = 1'b0;
    repeat (300) @(posedge core_clk);
    #1;
    chk("frozen_pin", 16'h0000, {15'h0, laser_pulse});
    clk_en = 1'b1;
    run(1'b0, n);
    chk("frozen_run", 16'(otc_pkg::OTC_LASER_PERIOD_CYC
      - otc_pkg::OTC_LASER_ON_CYC), 16'(n));
  endtask
  task automatic t_sleep();
    int n;
    wr(7'h06, 8'h08);
    chk("sleep_pin", 16'h0001, {15'h0, sleep_mode});
    mot(8'h01, 8'h01);
    run(1'b0, n);
    chk("dark_run", 16'h0fa0, 16'(n));
    wr(7'h51, 8'h03);
    rchk("emit_sleep", 7'h51, 8'h03);
    rchk("cfg_sleep", 7'h06, 8'h08);
    rchk("flag_sleep", 7'h02, 8'h00);
    wr(7'h06, 8'h00);
    chk("sleep_pin", 16'h0000, {15'h0, sleep_mode});
    repeat (WAKE) @(posedge core_clk);
    #1;
    run(1'b0, n);
    chk("wake_pulse", 16'h0001, {15'h0, laser_pulse});
  endtask
  task automatic t_srst();
    // Motion taken while awake, so the reset has state to clear
    mot(8'h02, 8'h02);
    rchk("flag_pre", 7'h02, 8'h80);
    rchk("dx_pre", 7'h03, 8'h02);
    mot(8'h02, 8'h02);
    wr(7'h06, 8'h08);
    wr(7'h51, 8'h06);
    wr(7'h06, 8'h88);
    chk("sleep_pin", 16'h0000, {15'h0, sleep_mode});
    chk("emit_pin", 16'h000e, {11'h0, emit});
    rchk("cfg_srst", 7'h06, 8'h00);
    // Snapshot read before the flag read, which would zero it anyway
    rchk("dx_srst", 7'h03, 8'h00);
    rchk("flag_srst", 7'h02, 8'h00);
    wr(7'h51, 8'h06);
  endtask
  // Verdict and end of run
  task automatic results();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence: reset for four cycles, then each scenario
  initial
  begin
    core_clk = 1'b0;
    nrst = 1'b0;
    clk_en = 1'b1;
    motion_stb = 1'b0;
    motion_dx = 8'h00;
    motion_dy = 8'h00;
    surface_quality_value = 8'h5a;
    repeat (4) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_motion();
    t_emit();
    t_pulse();
    t_sleep();
    t_srst();
    results();
  end
  // Watchdog: nearly four times the expected run
  initial
  begin
    repeat (60000) @(posedge core_clk);
    failures++;
    $display("ERROR watchdog expected done seen timeout");
    results();
  end
endmodule // otc_top_bench
